/* ocrf_pkg.sv */
// Constants, field layout and carrier types for the offcore response event filter
package ocrf_pkg;
  // Counter array shape
  localparam int NUM_CTR = 4;
  localparam int CTR_W = 32;
  localparam int OUT_W = 8;
  // Register indices as printed, byte address is four times the index
  localparam logic [9:0] IDX_CFG_A = 10'h1A6;
  localparam logic [9:0] IDX_CFG_B = 10'h1A7;
  localparam logic [11:0] A_CFGA_LO = {IDX_CFG_A, 2'b00};
  localparam logic [11:0] A_CFGB_LO = {IDX_CFG_B, 2'b00};
  localparam logic [11:0] A_CFGA_HI = 12'h6A0;
  localparam logic [11:0] A_CFGB_HI = 12'h6A4;
  localparam logic [11:0] A_STAT_LO = 12'h700;
  localparam logic [11:0] A_STAT_HI = 12'h704;
  localparam logic [11:0] A_SB_BASE = 12'h710;
  localparam logic [11:0] A_SB_LIMIT = 12'h714;
  localparam logic [11:0] A_SB_THRESH = 12'h718;
  localparam logic [11:0] A_SB_INDEX = 12'h71C;
  localparam logic [11:0] A_SB_APPL = 12'h720;
  // Per-counter banks, four words each, counter number in address bits 3:2
  localparam logic [7:0] BANK_EVTSEL = 8'h74;
  localparam logic [7:0] BANK_CTR = 8'h76;
  localparam logic [7:0] BANK_RELOAD = 8'h78;
  // Configuration register fields
  localparam int REQ_MSB = 15;
  localparam int RSP_LSB = 16;
  localparam int RSP_MSB = 37;
  localparam int ANY_RSP = 16;
  localparam int L2_HIT = 18;
  localparam int RSP_TRUE_MISS = 33;
  localparam int RSP_REMOTE_HIT_CLEAN = 34;
  localparam int RSP_REMOTE_HIT_DIRTY = 36;
  localparam int RSP_NON_MEMORY_TARGET = 37;
  localparam int OUTSTANDING = 38;
  localparam logic [15:0] REQ_USABLE = 16'hFFBF;
  localparam logic [63:0] CFG_A_WMASK = 64'h0000_0076_7FFF_FFBF;
  localparam logic [63:0] CFG_B_WMASK = 64'h0000_0036_7FFF_FFBF;
  localparam logic [63:0] CFG_RESET = 64'h0000_0000_0000_0000;
  // Counter select fields
  localparam logic [7:0] EVT_OFFCORE = 8'hB7;
  localparam logic [7:0] EVENT_UNIT_MASK_CFG_A = 8'h01;
  localparam logic [7:0] EVENT_UNIT_MASK_CFG_B = 8'h02;
  localparam int SEL_EN = 22;
  // Global status, high word holds bit 62
  localparam int STAT_SBOVF_HI = 30;
  // Sample buffer record length in bytes
  localparam logic [31:0] RECORD_BYTES = 32'h0000_00C8;
  // Bus answers
  localparam logic [1:0] RSP_OKAY = 2'h0;
  localparam logic [1:0] RSP_DECERR = 2'h3;

  // Completed offcore transaction with its response class
  typedef struct packed {
    logic valid;
    logic [15:0] reqType;
    logic [21:0] rspType;
  } ocrf_txn_t;

  // Request accepted by the external request queue
  typedef struct packed {
    logic valid;
    logic [15:0] reqType;
  } ocrf_accept_t;

  // Sample record write strobe
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [NUM_CTR-1:0] applMask;
  } ocrf_record_t;
endpackage

/* ocrf_filter_top.sv */
// Offcore response filter, event counters and sample buffer bounds logic
//
// Summary of operation
// - Index reaching threshold sets overflow bit 62
// - Out-of-bounds index also sets bit 62
// - Out-of-bounds clears status bits in applicable mask
// - Out-of-bounds leaves counters without reload
// - Unit mask 01H uses A, 02H uses B
// - Each core owns its own register pair
// - Bits 15:0 pick eligible request types
// - Bits 30:16 pick supplier or L2 hit
// - Snoop bits 33, 34, 36; 31,32,35 reserved
// - Bit 37 qualifies non-memory targets
// - Request bits 0-5 defined, bit 6 reserved
// - Request bits 7-15 further request classes
// - Bit 38 accumulates outstanding request cycles
// - Outstanding bit exists only in register A
// - Zero count without valid request and response
// - Response valid if bit 16, 18, 33, 34 or 36 set, or bit 38 in A
// - Several bits together match any combination
// - Record carries mask of requesting counters
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module ocrf_filter_top
  import ocrf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  input wire ocrf_txn_t txnDone,
  input wire ocrf_accept_t txnAccept,
  output ocrf_record_t recordWrite,
  output logic sbOverflow
);

  // Bus answer state
  logic waitReq_r;
  logic [31:0] readData_r;
  logic [1:0] resp_r;
  // Offcore configuration, one pair per instance, so one pair per core
  logic [63:0] cfgA_r;
  logic [63:0] cfgB_r;
  // Global status and sample buffer state
  logic [NUM_CTR-1:0] ovfStat_r;
  logic sbOvf_r;
  logic [31:0] sbBase_r;
  logic [31:0] sbLimit_r;
  logic [31:0] sbThresh_r;
  logic [31:0] sbIndex_r;
  logic [NUM_CTR-1:0] lastAppl_r;
  logic [NUM_CTR-1:0] pendMask_r;
  ocrf_record_t rec_r;
  // Outstanding request tally for register A
  logic [OUT_W-1:0] outCnt_r;
  // Per-counter state
  logic [31:0] evtSel_r [NUM_CTR];
  logic [CTR_W-1:0] ctr_r [NUM_CTR];
  logic [CTR_W-1:0] reload_r [NUM_CTR];
  logic [NUM_CTR-1:0] ovfEvt;
  logic [NUM_CTR-1:0] ctrWr;
  logic [CTR_W-1:0] ctrInc [NUM_CTR];

  // Byte-lane merge of a write
  function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // Write takes effect on the edge where the master sees waitrequest low
  wire wrTake = avs_write && !waitReq_r;
  wire [1:0] ctrSlot = avs_address[3:2];
  wire inBankSel = avs_address[11:4] == BANK_EVTSEL;
  wire inBankCtr = avs_address[11:4] == BANK_CTR;
  wire inBankRel = avs_address[11:4] == BANK_RELOAD;
  wire hitCfgALo = avs_address == A_CFGA_LO;
  wire hitCfgAHi = avs_address == A_CFGA_HI;
  wire hitCfgBLo = avs_address == A_CFGB_LO;
  wire hitCfgBHi = avs_address == A_CFGB_HI;
  wire hitStatLo = avs_address == A_STAT_LO;
  wire hitStatHi = avs_address == A_STAT_HI;
  wire hitBase = avs_address == A_SB_BASE;
  wire hitLimit = avs_address == A_SB_LIMIT;
  wire hitThresh = avs_address == A_SB_THRESH;
  wire hitIndex = avs_address == A_SB_INDEX;
  wire hitAppl = avs_address == A_SB_APPL;
  wire mapped = hitCfgALo || hitCfgAHi || hitCfgBLo || hitCfgBHi || hitStatLo || hitStatHi
    || hitBase || hitLimit || hitThresh || hitIndex || hitAppl || inBankSel || inBankCtr
    || inBankRel;

  // Write-one-to-clear masks for status
  wire [31:0] w1cLo = (wrTake && hitStatLo) ? beMerge(32'h0000_0000, avs_writedata,
                                                       avs_byteenable) : 32'h0000_0000;
  wire [31:0] w1cHi = (wrTake && hitStatHi) ? beMerge(32'h0000_0000, avs_writedata,
                                                       avs_byteenable) : 32'h0000_0000;

  // Read selection
  wire [31:0] statLo = {{(32 - NUM_CTR){1'b0}}, ovfStat_r};
  wire [31:0] statHi = {1'b0, sbOvf_r, 30'h0000_0000};
  wire [31:0] rdSel =
    hitCfgALo ? cfgA_r[31:0] :
    hitCfgAHi ? cfgA_r[63:32] :
    hitCfgBLo ? cfgB_r[31:0] :
    hitCfgBHi ? cfgB_r[63:32] :
    hitStatLo ? statLo :
    hitStatHi ? statHi :
    hitBase ? sbBase_r :
    hitLimit ? sbLimit_r :
    hitThresh ? sbThresh_r :
    hitIndex ? sbIndex_r :
    hitAppl ? {{(32 - NUM_CTR){1'b0}}, lastAppl_r} :
    inBankSel ? evtSel_r[ctrSlot] :
    inBankCtr ? ctr_r[ctrSlot] :
    inBankRel ? reload_r[ctrSlot] : 32'h0000_0000;

  // One wait cycle per request, answer registered with it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      waitReq_r <= 1'b1;
      readData_r <= 32'h0000_0000;
      resp_r <= RSP_OKAY;
    end else begin
      waitReq_r <= !((avs_read || avs_write) && waitReq_r);
      if ((avs_read || avs_write) && waitReq_r) begin
        readData_r <= avs_read ? rdSel : 32'h0000_0000;
        resp_r <= mapped ? RSP_OKAY : RSP_DECERR;
      end
    end
  end

  // Validity of the two filters
  // request field
  wire reqOkA = |(cfgA_r[REQ_MSB:0] & REQ_USABLE);
  wire reqOkB = |(cfgB_r[REQ_MSB:0] & REQ_USABLE);
  wire rspOkA = cfgA_r[ANY_RSP] | cfgA_r[L2_HIT] | cfgA_r[RSP_TRUE_MISS]
    | cfgA_r[RSP_REMOTE_HIT_CLEAN] | cfgA_r[RSP_REMOTE_HIT_DIRTY] | cfgA_r[OUTSTANDING];
  wire rspOkB = cfgB_r[ANY_RSP] | cfgB_r[L2_HIT] | cfgB_r[RSP_TRUE_MISS]
    | cfgB_r[RSP_REMOTE_HIT_CLEAN] | cfgB_r[RSP_REMOTE_HIT_DIRTY];
  wire validA = reqOkA && rspOkA;
  wire validB = reqOkB && rspOkB;
  wire outModeA = cfgA_r[OUTSTANDING];

  // Transaction matching
  // supplier and L2 hit qualify
  wire reqHitA = |(txnDone.reqType & cfgA_r[REQ_MSB:0] & REQ_USABLE);
  wire reqHitB = |(txnDone.reqType & cfgB_r[REQ_MSB:0] & REQ_USABLE);
  wire rspHitA = |(txnDone.rspType & cfgA_r[RSP_MSB:RSP_LSB]);
  wire rspHitB = |(txnDone.rspType & cfgB_r[RSP_MSB:RSP_LSB]);
  wire matchA = txnDone.valid && validA && !outModeA && reqHitA && rspHitA;
  wire matchB = txnDone.valid && validB && reqHitB && rspHitB;

  // Outstanding requests of the types chosen in A
  // response bits assumed zero here
  wire accHit = txnAccept.valid && |(txnAccept.reqType & cfgA_r[REQ_MSB:0] & REQ_USABLE);
  wire retHit = txnDone.valid && reqHitA;
  wire outFull = &outCnt_r;
  wire outEmpty = outCnt_r == '0;

  // Track accepted but unanswered requests, saturating
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      outCnt_r <= '0;
    end else if (accHit && !retHit && !outFull) begin
      outCnt_r <= outCnt_r + 1'b1;
    end else if (retHit && !accHit && !outEmpty) begin
      outCnt_r <= outCnt_r - 1'b1;
    end
  end

  // Per-counter increments for each filter
  // one per match, or the outstanding tally each cycle for A in outstanding mode
  wire [CTR_W-1:0] incA = outModeA ? ((validA) ? {{(CTR_W - OUT_W){1'b0}}, outCnt_r} : '0)
                                   : {{(CTR_W - 1){1'b0}}, matchA};
  wire [CTR_W-1:0] incB = {{(CTR_W - 1){1'b0}}, matchB};

  // Sample engine, one record per cycle while overflows are pending
  wire sampleGo = |pendMask_r;
  wire idxLow = sbIndex_r < sbBase_r;
  wire idxHigh = sbIndex_r > sbLimit_r;
  wire oob = idxLow || idxHigh;
  wire sampleOk = sampleGo && !oob;
  wire sampleBad = sampleGo && oob;
  wire [31:0] idxAdv = sbIndex_r + RECORD_BYTES;
  wire thrHit = sampleOk && (idxAdv >= sbThresh_r);

  // Counter bank
  for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
    wire [7:0] code = evtSel_r[i][7:0];
    wire [7:0] event_unit_mask = evtSel_r[i][15:8];
    wire useA = evtSel_r[i][SEL_EN] && code == EVT_OFFCORE && event_unit_mask == EVENT_UNIT_MASK_CFG_A;
    wire useB = evtSel_r[i][SEL_EN] && code == EVT_OFFCORE && event_unit_mask == EVENT_UNIT_MASK_CFG_B;
    wire [CTR_W:0] sum = {1'b0, ctr_r[i]} + {1'b0, ctrInc[i]};
    assign ctrInc[i] = useA ? incA : (useB ? incB : '0);
    assign ctrWr[i] = wrTake && inBankCtr && ctrSlot == 2'(i);
    assign ovfEvt[i] = sum[CTR_W] && !ctrWr[i];

    // Software write, reload after a good record, else count
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        ctr_r[i] <= '0;
        evtSel_r[i] <= '0;
        reload_r[i] <= '0;
      end else begin
        if (wrTake && inBankSel && ctrSlot == 2'(i)) begin
          evtSel_r[i] <= beMerge(evtSel_r[i], avs_writedata, avs_byteenable);
        end
        if (wrTake && inBankRel && ctrSlot == 2'(i)) begin
          reload_r[i] <= beMerge(reload_r[i], avs_writedata, avs_byteenable);
        end
        if (ctrWr[i]) begin
          ctr_r[i] <= beMerge(ctr_r[i], avs_writedata, avs_byteenable);
        // reload only on a good record
        end else if (sampleOk && pendMask_r[i]) begin
          ctr_r[i] <= reload_r[i];
        end else begin
          ctr_r[i] <= sum[CTR_W-1:0];
        end
      end
    end
  end

  // Configuration registers, reserved bits stay zero
  // private pair per instance
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfgA_r <= CFG_RESET;
      cfgB_r <= CFG_RESET;
    end else if (wrTake) begin
      if (hitCfgALo) cfgA_r[31:0] <= beMerge(cfgA_r[31:0], avs_writedata, avs_byteenable)
                                       & CFG_A_WMASK[31:0];
      if (hitCfgAHi) cfgA_r[63:32] <= beMerge(cfgA_r[63:32], avs_writedata, avs_byteenable)
                                        & CFG_A_WMASK[63:32];
      if (hitCfgBLo) cfgB_r[31:0] <= beMerge(cfgB_r[31:0], avs_writedata, avs_byteenable)
                                       & CFG_B_WMASK[31:0];
      if (hitCfgBHi) cfgB_r[63:32] <= beMerge(cfgB_r[63:32], avs_writedata, avs_byteenable)
                                        & CFG_B_WMASK[63:32];
    end
  end

  // Status flags, hardware set wins over clear
  // bad index clears applicable bits
  wire [NUM_CTR-1:0] oobClr = sampleBad ? pendMask_r : '0;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ovfStat_r <= '0;
      sbOvf_r <= 1'b0;
      pendMask_r <= '0;
    end else begin
      ovfStat_r <= (ovfStat_r & ~w1cLo[NUM_CTR-1:0] & ~oobClr) | ovfEvt;
      sbOvf_r <= (sbOvf_r && !w1cHi[STAT_SBOVF_HI]) || thrHit || sampleBad;
      pendMask_r <= ovfEvt;
    end
  end

  // Sample buffer pointers and record strobe
  // record holds requesting counters
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sbBase_r <= '0;
      sbLimit_r <= '0;
      sbThresh_r <= '0;
      sbIndex_r <= '0;
      lastAppl_r <= '0;
      rec_r <= '0;
    end else begin
      if (wrTake && hitBase) sbBase_r <= beMerge(sbBase_r, avs_writedata, avs_byteenable);
      if (wrTake && hitLimit) sbLimit_r <= beMerge(sbLimit_r, avs_writedata, avs_byteenable);
      if (wrTake && hitThresh) sbThresh_r <= beMerge(sbThresh_r, avs_writedata,
                                                     avs_byteenable);
      if (wrTake && hitIndex) begin
        sbIndex_r <= beMerge(sbIndex_r, avs_writedata, avs_byteenable);
      end else if (sampleOk) begin
        sbIndex_r <= idxAdv;
      end
      if (sampleOk) lastAppl_r <= pendMask_r;
      rec_r.valid <= sampleOk;
      rec_r.addr <= sampleOk ? sbIndex_r : rec_r.addr;
      rec_r.applMask <= sampleOk ? pendMask_r : rec_r.applMask;
    end
  end

  // Outputs straight from flops
  assign avs_waitrequest = waitReq_r;
  assign avs_readdata = readData_r;
  assign avs_response = resp_r;
  assign recordWrite = rec_r;
  assign sbOverflow = sbOvf_r;

  // Bus answers one cycle after the request
  // Handshake has one wait cycle
  bus_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (avs_read || avs_write) && waitReq_r |=> !waitReq_r ##1 waitReq_r)
    else $error("waitrequest did not drop for one cycle");
  thresh_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    thrHit && !(wrTake && (hitIndex || hitThresh)) |=> sbOvf_r && sbIndex_r >= sbThresh_r)
    else $error("threshold did not set buffer overflow");
  bounds_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sampleGo && (sbIndex_r < sbBase_r || sbIndex_r > sbLimit_r) |=> sbOvf_r && !rec_r.valid)
    else $error("out of bounds index did not flag");
  bounds_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sampleBad && ovfEvt == '0 |=> (ovfStat_r & $past(pendMask_r)) == '0)
    else $error("applicable status bits not cleared");
  no_reload_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sampleBad && pendMask_r[0] && !ctrWr[0] && ctrInc[0] == '0 |=> ctr_r[0] == $past(ctr_r[0]))
    else $error("counter changed on out of bounds record");
  cfgb_no_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wrTake && hitCfgBHi && avs_byteenable == 4'hF
      |=> cfgB_r[63:32] == ($past(avs_writedata) & CFG_B_WMASK[63:32]))
    else $error("outstanding bit present in second register");
  cfga_hi_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wrTake && hitCfgAHi && avs_byteenable == 4'hF
      |=> cfgA_r[63:32] == ($past(avs_writedata) & CFG_A_WMASK[63:32]))
    else $error("first register high word not loaded");
  zero_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    g_ctr[0].useA && !validA |-> ctrInc[0] == '0)
    else $error("count with invalid filter");
  zero_count_b_a: assert property (@(posedge mclk) disable iff (!rst_n)
    g_ctr[1].useB && !validB |-> ctrInc[1] == '0)
    else $error("count with invalid second filter");
  appl_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sampleOk |=> rec_r.valid && rec_r.applMask == $past(pendMask_r)
      && sbIndex_r == $past(sbIndex_r) + RECORD_BYTES || $past(wrTake && hitIndex))
    else $error("record mask or index wrong");
  plain_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    g_ctr[0].useA && matchA && !ctrWr[0] && !sampleOk |=> ctr_r[0] == $past(ctr_r[0]) + 1'b1)
    else $error("plain match did not add one");
  plain_count_b_a: assert property (@(posedge mclk) disable iff (!rst_n)
    g_ctr[1].useB && matchB && !ctrWr[1] && !sampleOk |=> ctr_r[1] == $past(ctr_r[1]) + 1'b1)
    else $error("second filter match did not add one");
  busy_accum_a: assert property (@(posedge mclk) disable iff (!rst_n)
    g_ctr[0].useA && outModeA && validA && !ctrWr[0] && !sampleOk
      |=> ctr_r[0] == $past(ctr_r[0]) + $past(outCnt_r))
    else $error("outstanding tally not added");

  // Main scenarios
  cov_bad_idx: cover property (@(posedge mclk) disable iff (!rst_n) sampleBad);
  cov_thresh: cover property (@(posedge mclk) disable iff (!rst_n) thrHit);
  cov_outst: cover property (@(posedge mclk) disable iff (!rst_n) outModeA && outCnt_r > 1);
  cov_record: cover property (@(posedge mclk) disable iff (!rst_n) rec_r.valid);
  cov_plain_b: cover property (@(posedge mclk) disable iff (!rst_n) matchB && g_ctr[1].useB);

endmodule // ocrf_filter_top

/* testbench.sv */
// Self-checking bench for the offcore response filter and sample buffer bounds
`timescale 1ns/1ps
module testbench;
  import ocrf_pkg::*;
  logic mclk, rst_n, avsRead, avsWrite, avsWait, sbOverflow;
  logic [11:0] avsAddr;
  logic [31:0] avsWdata, avsRdata, rdData;
  logic [1:0] avsResp, rdResp;
  ocrf_txn_t txnDone;
  ocrf_accept_t txnAccept;
  ocrf_record_t recordWrite;
  int err_total, check_count, seed;
  // Model state: filter words, plain counts, logged records
  logic [63:0] cfgM [2];
  logic [31:0] ctrM [2];
  logic [35:0] recQ [$];
  // Config word addresses and their writable bits
  logic [11:0] cfgAdr [4] = '{A_CFGA_LO, A_CFGA_HI, A_CFGB_LO, A_CFGB_HI};
  logic [31:0] cfgMsk [4] = '{32'h7FFF_FFBF, 32'h0000_0076, 32'h7FFF_FFBF, 32'h0000_0036};
  // Counter selects: A, B, other code, disabled
  logic [31:0] selV [4] = '{32'h0040_01B7, 32'h0040_02B7, 32'h0040_01C0, 32'h0000_01B7};
  logic [31:0] idxV [4] = '{32'h0000_1000, 32'h0000_10C8, 32'h0000_0F00, 32'h0000_2004};

  // Core clock, 40 ns period
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ocrf_filter_top i_dut (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avsAddr), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_byteenable(4'hF), .avs_writedata(avsWdata),
    .avs_readdata(avsRdata), .avs_response(avsResp), .avs_waitrequest(avsWait),
    .txnDone(txnDone), .txnAccept(txnAccept), .recordWrite(recordWrite),
    .sbOverflow(sbOverflow)
  );

  // Log every record the block emits
  always @(posedge mclk)
    if (recordWrite.valid === 1'b1) recQ.push_back({recordWrite.addr, recordWrite.applMask});

  // Compare one result and count it
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avsRead <= ~wr;
    avsWrite <= wr;
    avsAddr <= a;
    avsWdata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avsWait !== 1'b0 && n < 50);
    rdData = avsRdata;
    rdResp = avsResp;
    if (n >= 50) chk("bus answer", 1'b1, 1'b0);
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Read a mapped word and check data and an okay answer
  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, exp, rdData);
    chk("response", RSP_OKAY, rdResp);
  endtask

  // Filter decision written from the field rules
  function automatic bit hit(input logic [63:0] c, input logic [15:0] rq, input logic [21:0] rs);
    bit ok;
    ok = c[16] | c[18] | c[33] | c[34] | c[36] | c[38];
    return ok && (|(rq & c[15:0] & 16'hFFBF)) && (|(rs & c[37:16]));
  endfunction

  // One completed transaction, model counts alongside
  task automatic txn(input logic [15:0] rq, input logic [21:0] rs);
    @(posedge mclk);
    txnDone <= '{1'b1, rq, rs};
    for (int k = 0; k < 2; k++)
      if (hit(cfgM[k], rq, rs)) ctrM[k] = ctrM[k] + 32'h1;
    @(posedge mclk);
    txnDone <= '0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    $display("[ERR] watchdog expected finish seen hang");
    tally_and_finish;
  end

  // Main sequence
  initial begin
    logic [31:0] lo;
    logic [15:0] rq;
    logic [21:0] rs;
    bit oob;
    seed = 72;
    rst_n = 1'b0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddr = 12'h000;
    avsWdata = 32'h0000_0000;
    txnDone = '0;
    txnAccept = '0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("waitrequest idle", 1'b1, avsWait);
    chk("overflow pin", 1'b0, sbOverflow);
    chk("record valid", 1'b0, recordWrite.valid);
    for (int k = 0; k < 4; k++) rdc("cfg reset", cfgAdr[k], 32'h0000_0000);
    wr(12'hFFC, 32'hFFFF_FFFF);
    bus(1'b0, 12'hFFC, 32'h0000_0000);
    chk("unmapped data", 32'h0000_0000, rdData);
    chk("unmapped response", RSP_DECERR, rdResp);
    $display("test reset and map done");
    for (int k = 0; k < 4; k++) wr({BANK_EVTSEL, k[1:0], 2'b00}, selV[k]);
    // Random filters against random single-type transactions
    for (int r = 0; r < 6; r++) begin
      for (int k = 0; k < 4; k++) begin
        lo = $random(seed) & $random(seed);
        if (k == 1) lo[6] = 1'b0;
        if (r == 0 && k == 0) lo = 32'h0001_0040;
        cfgM[k/2][32*(k%2) +: 32] = lo & cfgMsk[k];
        wr(cfgAdr[k], lo);
        rdc("cfg readback", cfgAdr[k], lo & cfgMsk[k]);
      end
      for (int k = 0; k < 2; k++) wr({BANK_CTR, k[1:0], 2'b00}, 32'h0000_0000);
      ctrM[0] = 32'h0000_0000;
      ctrM[1] = 32'h0000_0000;
      for (int t = 0; t < 8; t++) begin
        rq = 16'h0001 << ($unsigned($random(seed)) % 16);
        rs = 22'h000001 | (22'h000001 << ($unsigned($random(seed)) % 22));
        txn(rq, rs);
      end
      for (int k = 0; k < 4; k++)
        rdc("counter", {BANK_CTR, k[1:0], 2'b00}, k < 2 ? ctrM[k] : 32'h0000_0000);
    end
    $display("test filter counting done");
    // Software keeps bits 37:16 clear in outstanding mode
    wr(A_CFGA_LO, 32'h0000_0001);
    wr(A_CFGA_HI, 32'h0000_0040);
    wr({BANK_CTR, 4'h0}, 32'h0000_0000);
    @(posedge mclk);
    txnAccept <= '{1'b1, 16'h0001};
    repeat (2) @(posedge mclk);
    txnAccept <= '0;
    repeat (10) @(posedge mclk);
    txn(16'h0001, 22'h000001);
    txn(16'h0001, 22'h000001);
    bus(1'b0, {BANK_CTR, 4'h0}, 32'h0000_0000);
    lo = rdData;
    chk("busy cycles in range", 1'b1, lo >= 32'd20 && lo <= 32'd36);
    rdc("busy count settles", {BANK_CTR, 4'h0}, lo);
    $display("test outstanding done");
    wr(A_CFGA_HI, 32'h0000_0000);
    wr(A_CFGA_LO, 32'h0001_0001);
    cfgM[0] = 64'h0000_0000_0001_0001;
    wr(A_SB_BASE, 32'h0000_1000);
    wr(A_SB_LIMIT, 32'h0000_2000);
    wr(A_SB_THRESH, 32'h0000_1190);
    wr(A_SB_INDEX, 32'h0000_1000);
    wr({BANK_RELOAD, 4'h0}, 32'h0000_0100);
    recQ.delete();
    // Two in-bounds overflows, then below base and above limit
    for (int p = 0; p < 4; p++) begin
      oob = p >= 2;
      if (oob) wr(A_SB_INDEX, idxV[p]);
      wr({BANK_CTR, 4'h0}, 32'hFFFF_FFFF);
      txn(16'h0001, 22'h000001);
      repeat (4) @(posedge mclk);
      chk("record count", oob ? 0 : 1, recQ.size());
      if (!oob) chk("record", {idxV[p], 4'h1}, recQ.pop_front());
      rdc("counter after overflow", {BANK_CTR, 4'h0}, oob ? 32'h0 : 32'h100);
      rdc("index", A_SB_INDEX, oob ? idxV[p] : idxV[p] + 32'h0000_00C8);
      rdc("counter status", A_STAT_LO, oob ? 32'h0 : 32'h1);
      rdc("applicable mask", A_SB_APPL, 32'h0000_0001);
      chk("overflow pin", p != 0, sbOverflow);
      rdc("status high", A_STAT_HI, p != 0 ? 32'h4000_0000 : 32'h0);
      wr(A_STAT_HI, 32'h4000_0000);
      wr(A_STAT_LO, 32'h0000_000F);
    end
    $display("test sample buffer done");
    tally_and_finish;
  end
endmodule // testbench
